// [rtl/uepd_pkg.sv]
// Shared constants for the bulk endpoint DMA request block and its partner
package uepd_pkg;
  // Register addresses on the local microcontroller bus
  localparam logic [7:0] ADDR_PIN_POLARITY_SELECT  = 8'h01;
  localparam logic [7:0] ADDR_DMA_CONTROL          = 8'h02;
  localparam logic [7:0] ADDR_DMA_REQUEST_INTERVAL = 8'h03;

  // Reset values
  localparam logic [7:0] RST_PIN_POLARITY_SELECT   = 8'h00;
  localparam logic [7:0] RST_DMA_CONTROL           = 8'h00;
  localparam logic [7:0] RST_DMA_REQUEST_INTERVAL  = 8'h00;
  localparam logic [7:0] UNMAPPED_READ             = 8'h00;

  // Polarity select fields
  localparam int POL_IRQ_BIT = 0;
  localparam int POL_REQ_BIT = 1;
  localparam int POL_ACK_BIT = 2;

  // DMA control fields
  localparam int CTL_ENABLE_BIT = 0;
  localparam int CTL_DUAL_BIT   = 1;
  localparam int CTL_COUNT_BIT  = 2;
  localparam int CTL_WIDE_BIT   = 3;
  localparam int CTL_DEMAND_BIT = 4;
  localparam int CTL_PAUSE_BIT  = 7;

  // Data layout
  localparam int             CNT_W    = 7;
  localparam int             DATA_W   = 16;
  localparam logic [7:0]     PAD_BYTE = 8'h00;
  localparam int             MAX_PKT_DEFAULT = 64;

  // Request spacing in single transfer mode
  localparam int CLK_PERIOD_NS  = 8;
  localparam int BIT_TIME_NS    = 84;
  localparam int REQ_ENABLE_NS  = 8;
  localparam int BIT_TIME_CYC   = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REQ_ENABLE_CYC = (REQ_ENABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_W          = 12;

  typedef enum logic [1:0] {RX_IDLE, RX_COUNT, RX_DATA, RX_DRAIN} uepd_rx_state_type;
  typedef enum logic [1:0] {H_IDLE, H_READ, H_WRITE} uepd_host_state_type;
endpackage : uepd_pkg

// [rtl/uepd_link_if.sv]
// Link between the endpoint DMA block and the DMA controller / microcontroller
`timescale 1ns/10ps
interface uepd_link_if;
  logic        dma_request_out;
  logic        dma_acknowledge_in;
  logic        dma_port_sel;
  logic        dma_rd;
  logic        dma_wr;
  logic [15:0] dma_wdata;
  logic [15:0] dma_rdata;
  logic        interrupt_request_pin;
  logic        mcu_cs;
  logic        mcu_wr;
  logic [7:0]  mcu_addr;
  logic [7:0]  mcu_wdata;
  logic [7:0]  mcu_rdata;

  modport device_end (
    output dma_request_out, dma_rdata, interrupt_request_pin, mcu_rdata,
    input  dma_acknowledge_in, dma_port_sel, dma_rd, dma_wr, dma_wdata,
    input  mcu_cs, mcu_wr, mcu_addr, mcu_wdata
  );
  modport host_end (
    input  dma_request_out, dma_rdata, interrupt_request_pin, mcu_rdata,
    output dma_acknowledge_in, dma_port_sel, dma_rd, dma_wr, dma_wdata,
    output mcu_cs, mcu_wr, mcu_addr, mcu_wdata
  );
endinterface : uepd_link_if

// [rtl/uepd_device.sv]
// Device end: DMA request logic of the first bulk endpoint plus pin polarities
`timescale 1ns/10ps
// Notes on behaviour
// - DMA serves only the first bulk endpoint.
// - Polarity D2 sets acknowledge level, 1 low.
// - Polarity D1 sets request level, 1 high.
// - After any reset: request low, acknowledge high.
// - Transmit requests until packet ready, again after ACK.
// - Good received packet sets ready and requests.
// - All bytes read out clears ready, drops request.
// - Control D0 enables requests at all.
// - Control D1 picks acknowledge or port select.
// - Control D4 picks single or demand transfer.
// - Single drops request per word; demand holds.
// - Control D2 prefixes received data with count.
// - Control D3 selects 8 or 16 bit.
// - Sixteen-bit words are little endian.
// - Odd final byte gets 00h upper byte.
// - Single mode gap: enable time plus n*84ns.
// - Microcontroller fixes control bits before first token.
// - Transmit packet ready sets at max packet size.
// - Microcontroller sets ready for short final packet.
// - Polarity D0 sets interrupt level, reset low.
// - Edge-triggered hosts rewrite enables to force edge.
module uepd_device #(
  parameter int MAX_PKT = uepd_pkg::MAX_PKT_DEFAULT
) (
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  uepd_link_if.device_end                link,
  input  wire logic                      soft_reset,
  input  wire logic                      ep_dir_in,
  input  wire logic                      rx_pkt_good,
  input  wire logic [uepd_pkg::CNT_W-1:0] rx_pkt_count,
  input  wire logic                      rx_in_valid,
  input  wire logic [7:0]                rx_in_data,
  output logic                           rx_in_ready,
  input  wire logic                      tx_fifo_prepared,
  input  wire logic                      tx_sent_ack,
  input  wire logic                      tx_set_ready,
  output logic                           tx_out_valid,
  output logic [7:0]                     tx_out_data,
  input  wire logic                      tx_out_ready,
  input  wire logic                      irq_pending,
  output logic                           rx_pkt_ready,
  output logic                           tx_pkt_ready
);
  import uepd_pkg::*;
  localparam logic [CNT_W-1:0] MAX_CNT = CNT_W'(MAX_PKT);
  logic [7:0]         pin_polarity_select_reg;
  logic [7:0]         ctrl_reg;
  logic [7:0]         intvl_reg;
  logic [7:0]         rdata_reg;
  uepd_rx_state_type  rx_state_reg;
  logic [CNT_W-1:0]   rx_left_reg;
  logic [CNT_W-1:0]   rx_count_reg;
  logic [7:0]         rx_lo_reg;
  logic               rx_have_lo_reg;
  logic [DATA_W-1:0]  buf_mem [2];
  logic               buf_wp_reg;
  logic               buf_rp_reg;
  logic [1:0]         buf_cnt_reg;
  logic [DATA_W-1:0]  tx_hold_reg;
  logic [1:0]         tx_hold_n_reg;
  logic [CNT_W-1:0]   tx_cnt_reg;
  logic               tx_rdy_reg;
  logic [GAP_W-1:0]   gap_reg;
  logic               asm_valid;
  logic [DATA_W-1:0]  asm_data;
  logic               rx_take;
  logic               push;
  logic               ack_act;
  logic               port_hit;
  logic               rd_hit;
  logic               wr_hit;
  logic               req_cond;
  logic               req_act;
  logic [CNT_W-1:0]   tx_step;
  logic [CNT_W:0]     tx_sum;
  wire wide     = ctrl_reg[CTL_WIDE_BIT];
  wire buf_ok   = (buf_cnt_reg != 2'h2);
  // Microcontroller register port; both resets restore polarities
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_polarity_select_reg <= RST_PIN_POLARITY_SELECT;
      ctrl_reg   <= RST_DMA_CONTROL;
      intvl_reg  <= RST_DMA_REQUEST_INTERVAL;
    end else if (soft_reset) begin
      pin_polarity_select_reg <= RST_PIN_POLARITY_SELECT;
      ctrl_reg   <= RST_DMA_CONTROL;
      intvl_reg  <= RST_DMA_REQUEST_INTERVAL;
    end else if (link.mcu_cs && link.mcu_wr) begin
      if (link.mcu_addr == ADDR_PIN_POLARITY_SELECT) pin_polarity_select_reg <= link.mcu_wdata;
      if (link.mcu_addr == ADDR_DMA_CONTROL)         ctrl_reg   <= link.mcu_wdata;
      if (link.mcu_addr == ADDR_DMA_REQUEST_INTERVAL) intvl_reg <= link.mcu_wdata;
    end
  end
  // Read data registered one cycle after the select
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= UNMAPPED_READ;
    end else if (link.mcu_cs && !link.mcu_wr) begin
      unique case (link.mcu_addr)
        ADDR_PIN_POLARITY_SELECT:  rdata_reg <= pin_polarity_select_reg;
        ADDR_DMA_CONTROL:          rdata_reg <= ctrl_reg;
        ADDR_DMA_REQUEST_INTERVAL: rdata_reg <= intvl_reg;
        default:                   rdata_reg <= UNMAPPED_READ;
      endcase
    end
  end
  assign link.mcu_rdata = rdata_reg;
  // Access decode: acknowledge selects the port only in single address mode
  assign ack_act  = pin_polarity_select_reg[POL_ACK_BIT] ? !link.dma_acknowledge_in
                                            : link.dma_acknowledge_in;
  assign port_hit = ctrl_reg[CTL_DUAL_BIT] ? link.dma_port_sel : ack_act;
  assign rd_hit   = link.dma_rd && port_hit && !ep_dir_in && (buf_cnt_reg != 2'h0);
  assign wr_hit   = link.dma_wr && port_hit && ep_dir_in && !tx_rdy_reg
                    && (tx_hold_n_reg == 2'h0) && tx_fifo_prepared;
  // Assemble received bytes into transfer words
  always_comb begin
    asm_valid = 1'b0;
    asm_data  = {PAD_BYTE, PAD_BYTE};
    rx_take   = 1'b0;
    unique case (rx_state_reg)
      RX_COUNT: begin
        asm_valid = 1'b1;
        asm_data  = {PAD_BYTE, 1'b0, rx_count_reg};
      end
      RX_DATA: begin
        if (wide) begin
          if (rx_have_lo_reg && rx_left_reg == '0) begin
            asm_valid = 1'b1;
            asm_data  = {PAD_BYTE, rx_lo_reg};
          end else if (rx_have_lo_reg) begin
            asm_valid = rx_in_valid;
            asm_data  = {rx_in_data, rx_lo_reg};
            rx_take   = rx_in_valid && buf_ok;
          end else begin
            rx_take   = rx_in_valid && (rx_left_reg != '0);
          end
        end else if (rx_left_reg != '0) begin
          asm_valid = rx_in_valid;
          asm_data  = {PAD_BYTE, rx_in_data};
          rx_take   = rx_in_valid && buf_ok;
        end
      end
      RX_IDLE, RX_DRAIN: begin
        asm_valid = 1'b0;
      end
    endcase
  end
  assign rx_in_ready = rx_take;
  assign push        = asm_valid && buf_ok;
  // Receive packet tracking; only this endpoint ever loads a packet
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_state_reg   <= RX_IDLE;
      rx_left_reg    <= '0;
      rx_count_reg   <= '0;
      rx_lo_reg      <= PAD_BYTE;
      rx_have_lo_reg <= 1'b0;
    end else if (soft_reset) begin
      rx_state_reg   <= RX_IDLE;
      rx_have_lo_reg <= 1'b0;
    end else begin
      if (rx_take) begin
        rx_left_reg <= rx_left_reg - 1'b1;
        if (wide && !rx_have_lo_reg) begin
          rx_lo_reg      <= rx_in_data;
          rx_have_lo_reg <= 1'b1;
        end
      end
      if (push && rx_state_reg == RX_DATA && wide) rx_have_lo_reg <= 1'b0;
      unique case (rx_state_reg)
        RX_IDLE: if (rx_pkt_good && !ep_dir_in) begin
          rx_left_reg  <= rx_pkt_count;
          rx_count_reg <= rx_pkt_count;
          rx_state_reg <= ctrl_reg[CTL_COUNT_BIT] ? RX_COUNT : RX_DATA;
        end
        RX_COUNT: if (push) rx_state_reg <= RX_DATA;
        RX_DATA: if (rx_left_reg == '0 && !rx_have_lo_reg) rx_state_reg <= RX_DRAIN;
        RX_DRAIN: if (buf_cnt_reg == 2'h0) rx_state_reg <= RX_IDLE;
      endcase
    end
  end
  assign rx_pkt_ready = (rx_state_reg != RX_IDLE);
  // Two-entry buffer so a stalled controller loses no word
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      buf_wp_reg  <= 1'b0;
      buf_rp_reg  <= 1'b0;
      buf_cnt_reg <= 2'h0;
    end else if (soft_reset) begin
      buf_wp_reg  <= 1'b0;
      buf_rp_reg  <= 1'b0;
      buf_cnt_reg <= 2'h0;
    end else begin
      if (push) buf_wp_reg <= !buf_wp_reg;
      if (rd_hit) buf_rp_reg <= !buf_rp_reg;
      buf_cnt_reg <= buf_cnt_reg + {1'b0, push} - {1'b0, rd_hit};
    end
  end
  // Storage carries no reset; only written entries are ever read
  always_ff @(posedge sys_clk) begin
    if (push) buf_mem[buf_wp_reg] <= asm_data;
  end
  assign link.dma_rdata = buf_mem[buf_rp_reg];
  // Transmit byte accounting; set wins over the clear from the host ACK
  assign tx_step = wide ? CNT_W'(2) : CNT_W'(1);
  assign tx_sum  = {1'b0, tx_cnt_reg} + {1'b0, tx_step};
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_cnt_reg <= '0;
      tx_rdy_reg <= 1'b0;
    end else if (soft_reset) begin
      tx_cnt_reg <= '0;
      tx_rdy_reg <= 1'b0;
    end else if (wr_hit && tx_sum >= {1'b0, MAX_CNT}) begin
      tx_cnt_reg <= '0;
      tx_rdy_reg <= 1'b1;
    end else begin
      if (wr_hit) tx_cnt_reg <= tx_sum[CNT_W-1:0];
      if (tx_set_ready) begin
        tx_cnt_reg <= '0;
        tx_rdy_reg <= 1'b1;
      end else if (tx_sent_ack) begin
        tx_rdy_reg <= 1'b0;
      end
    end
  end
  assign tx_pkt_ready = tx_rdy_reg;
  // Split written words into FIFO bytes, low lane first
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_hold_reg   <= '0;
      tx_hold_n_reg <= 2'h0;
    end else if (soft_reset) begin
      tx_hold_n_reg <= 2'h0;
    end else if (wr_hit) begin
      tx_hold_reg   <= link.dma_wdata;
      tx_hold_n_reg <= wide ? 2'h2 : 2'h1;
    end else if (tx_out_valid && tx_out_ready) begin
      tx_hold_reg   <= {PAD_BYTE, tx_hold_reg[15:8]};
      tx_hold_n_reg <= tx_hold_n_reg - 2'h1;
    end
  end
  assign tx_out_valid = (tx_hold_n_reg != 2'h0);
  assign tx_out_data  = tx_hold_reg[7:0];
  // Single mode spacing after every completed word
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gap_reg <= '0;
    end else if (soft_reset) begin
      gap_reg <= '0;
    end else if ((rd_hit || wr_hit) && !ctrl_reg[CTL_DEMAND_BIT]) begin
      gap_reg <= GAP_W'(REQ_ENABLE_CYC) + GAP_W'(intvl_reg) * GAP_W'(BIT_TIME_CYC);
    end else if (gap_reg != '0) begin
      gap_reg <= gap_reg - 1'b1;
    end
  end
  // Request gating and pin polarities
  assign req_cond = ep_dir_in ? (tx_fifo_prepared && !tx_rdy_reg && tx_hold_n_reg == 2'h0)
                              : (rx_pkt_ready && buf_cnt_reg != 2'h0);
  assign req_act  = ctrl_reg[CTL_ENABLE_BIT] && !ctrl_reg[CTL_PAUSE_BIT]
                    && req_cond && (gap_reg == '0);
  assign link.dma_request_out = pin_polarity_select_reg[POL_REQ_BIT] ? req_act : !req_act;
  assign link.interrupt_request_pin = pin_polarity_select_reg[POL_IRQ_BIT] ? irq_pending
                                                              : !irq_pending;
endmodule : uepd_device

// [rtl/uepd_host.sv]
// Far end: DMA controller strobes and microcontroller register access
`timescale 1ns/10ps
module uepd_host (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  uepd_link_if.host_end    link,
  input  wire logic        cfg_valid,
  input  wire logic        cfg_write,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [7:0]  cfg_wdata,
  output logic [7:0]       cfg_rdata,
  output logic             cfg_rvalid,
  input  wire logic        xfer_dir_in,
  input  wire logic        wr_in_valid,
  input  wire logic [15:0] wr_in_data,
  output logic             wr_in_ready,
  output logic             rd_out_valid,
  output logic [15:0]      rd_out_data,
  input  wire logic        rd_out_ready,
  output logic             irq_out
);
  import uepd_pkg::*;

  uepd_host_state_type state_reg;
  logic [7:0]          pol_shadow_reg;
  logic                dual_shadow_reg;
  logic [15:0]         wdata_reg;
  logic                rvalid_reg;
  logic [15:0]         rdata_reg;
  logic                cfg_rvalid_reg;
  logic                req_seen;
  logic                access;

  // Register access passes straight to the device bus
  assign link.mcu_cs    = cfg_valid;
  assign link.mcu_wr    = cfg_write;
  assign link.mcu_addr  = cfg_addr;
  assign link.mcu_wdata = cfg_wdata;
  assign cfg_rdata      = link.mcu_rdata;
  assign cfg_rvalid     = cfg_rvalid_reg;

  // Shadows of what was written, so the pins can be decoded locally
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pol_shadow_reg  <= RST_PIN_POLARITY_SELECT;
      dual_shadow_reg <= 1'b0;
      cfg_rvalid_reg  <= 1'b0;
    end else begin
      cfg_rvalid_reg <= cfg_valid && !cfg_write;
      if (cfg_valid && cfg_write && cfg_addr == ADDR_PIN_POLARITY_SELECT)
        pol_shadow_reg <= cfg_wdata;
      if (cfg_valid && cfg_write && cfg_addr == ADDR_DMA_CONTROL)
        dual_shadow_reg <= cfg_wdata[CTL_DUAL_BIT];
    end
  end

  assign req_seen = pol_shadow_reg[POL_REQ_BIT] ? link.dma_request_out
                                                : !link.dma_request_out;
  assign irq_out  = pol_shadow_reg[POL_IRQ_BIT] ? link.interrupt_request_pin
                                                : !link.interrupt_request_pin;

  // One access, then an idle cycle so the device can update its request
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= H_IDLE;
      wdata_reg <= '0;
    end else begin
      unique case (state_reg)
        H_IDLE: begin
          if (req_seen && xfer_dir_in && wr_in_valid) begin
            state_reg <= H_WRITE;
            wdata_reg <= wr_in_data;
          end else if (req_seen && !xfer_dir_in && !rvalid_reg) begin
            state_reg <= H_READ;
          end
        end
        H_READ, H_WRITE: state_reg <= H_IDLE;
      endcase
    end
  end
  assign wr_in_ready = (state_reg == H_IDLE) && req_seen && xfer_dir_in;

  // Strobes and select active high; acknowledge at the chosen polarity
  assign access                  = (state_reg != H_IDLE);
  assign link.dma_rd             = (state_reg == H_READ);
  assign link.dma_wr             = (state_reg == H_WRITE);
  assign link.dma_wdata          = wdata_reg;
  assign link.dma_port_sel       = access && dual_shadow_reg;
  assign link.dma_acknowledge_in = pol_shadow_reg[POL_ACK_BIT] ? !(access && !dual_shadow_reg)
                                                               : (access && !dual_shadow_reg);

  // Read word holding register with back-pressure from the user
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
    end else if (state_reg == H_READ) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= link.dma_rdata;
    end else if (rd_out_ready) begin
      rvalid_reg <= 1'b0;
    end
  end
  assign rd_out_valid = rvalid_reg;
  assign rd_out_data  = rdata_reg;
endmodule : uepd_host

// [verification/uepd_properties.sv]
// Concurrent checks on the link between the endpoint DMA block and its host end
`timescale 1ns/10ps
module uepd_properties_chk (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       dma_request_out,
  input wire logic       dma_acknowledge_in,
  input wire logic       dma_port_sel,
  input wire logic       dma_rd,
  input wire logic       dma_wr,
  input wire logic       mcu_cs,
  input wire logic       mcu_wr,
  input wire logic [7:0] mcu_addr,
  input wire logic [7:0] mcu_wdata,
  input wire logic [7:0] mcu_rdata
);
  import uepd_pkg::*;
  logic [7:0]       pol_reg;
  logic [7:0]       ctl_reg;
  logic [7:0]       ivl_reg;
  logic [GAP_W-1:0] gap_reg;
  logic [7:0]       rd_exp;
  logic             req_act;
  logic             sel;
  logic             taken;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Decoded pin levels; shadows follow the microcontroller writes
  assign req_act = (dma_request_out == pol_reg[POL_REQ_BIT]);
  assign sel     = ctl_reg[CTL_DUAL_BIT] ? dma_port_sel : (dma_acknowledge_in ^ pol_reg[POL_ACK_BIT]);
  assign taken   = (dma_rd | dma_wr) & sel & req_act & ~ctl_reg[CTL_DEMAND_BIT];

  // Expected read data, unmapped places read fixed
  always_comb begin
    case (mcu_addr)
      ADDR_PIN_POLARITY_SELECT:  rd_exp = pol_reg;
      ADDR_DMA_CONTROL:          rd_exp = ctl_reg;
      ADDR_DMA_REQUEST_INTERVAL: rd_exp = ivl_reg;
      default:                   rd_exp = UNMAPPED_READ;
    endcase
  end

  // Register shadows; reset input also carries the soft reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pol_reg <= RST_PIN_POLARITY_SELECT;
      ctl_reg <= RST_DMA_CONTROL;
      ivl_reg <= RST_DMA_REQUEST_INTERVAL;
    end else if (mcu_cs && mcu_wr) begin
      if (mcu_addr == ADDR_PIN_POLARITY_SELECT) pol_reg <= mcu_wdata;
      if (mcu_addr == ADDR_DMA_CONTROL) ctl_reg <= mcu_wdata;
      if (mcu_addr == ADDR_DMA_REQUEST_INTERVAL) ivl_reg <= mcu_wdata;
    end
  end

  // Quiet-time counter; too long for a repetition operator
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) gap_reg <= '0;
    else if (taken) gap_reg <= GAP_W'(REQ_ENABLE_CYC + BIT_TIME_CYC * int'(ivl_reg));
    else if (gap_reg != '0) gap_reg <= gap_reg - 1'b1;
  end

  chk_reset_req_idle: assert property ($fell(rst) |-> dma_request_out)
    else $error("request pin active after reset");
  chk_req_needs_enable: assert property (!ctl_reg[CTL_ENABLE_BIT] |-> !req_act)
    else $error("request active while disabled");
  chk_req_pause_idle: assert property (ctl_reg[CTL_PAUSE_BIT] |-> !req_act)
    else $error("request active while paused");
  chk_single_drop: assert property (taken |=> !req_act)
    else $error("request held after a single transfer");
  chk_single_gap_len: assert property (gap_reg != '0 |-> !req_act)
    else $error("request back before the interval ran out");
  chk_strobe_spacing: assert property ((dma_rd || dma_wr) |=> !dma_rd && !dma_wr)
    else $error("strobes back to back");
  chk_strobe_apart: assert property (dma_rd |-> !dma_wr)
    else $error("read and write strobes together");
  chk_reg_readback: assert property (mcu_cs && !mcu_wr |=> mcu_rdata == $past(rd_exp))
    else $error("register read data wrong");
  chk_rdata_hold: assert property (!(mcu_cs && !mcu_wr) |=> $stable(mcu_rdata))
    else $error("read data moved without a read");

  cover property (taken);
  cover property (dma_wr && req_act);
  cover property ($rose(req_act));
  cover property (mcu_cs && !mcu_wr && mcu_addr == ADDR_DMA_CONTROL);
endmodule : uepd_properties_chk

// [verification/usb_bulk_ep_dma_request_interface_bench.sv]
// Self-checking bench for the endpoint DMA block facing its host end
`timescale 1ns/10ps
module usb_bulk_ep_dma_request_interface_bench;
  import uepd_pkg::*;
  logic        sys_clk, rst, soft_reset, ep_dir_in, rx_pkt_good, rx_in_valid, rx_in_ready;
  logic        tx_fifo_prepared, tx_sent_ack, tx_set_ready, tx_out_valid, tx_out_ready;
  logic        irq_pending, rx_pkt_ready, tx_pkt_ready, cfg_valid, cfg_write, cfg_rvalid;
  logic        xfer_dir_in, wr_in_valid, wr_in_ready, rd_out_valid, rd_out_ready, irq_out;
  logic [6:0]  rx_pkt_count;
  logic [7:0]  rx_in_data, tx_out_data, cfg_addr, cfg_wdata, cfg_rdata;
  logic [15:0] wr_in_data, rd_out_data;
  logic [7:0]  tx_seen[$];
  int          error_cnt, n_compared, cyc;

  uepd_link_if uepd_link_if_inst ();
  uepd_device #(.MAX_PKT(4)) uepd_device_inst (.sys_clk, .rst, .link(uepd_link_if_inst),
    .soft_reset, .ep_dir_in, .rx_pkt_good, .rx_pkt_count, .rx_in_valid, .rx_in_data, .rx_in_ready,
    .tx_fifo_prepared, .tx_sent_ack, .tx_set_ready, .tx_out_valid, .tx_out_data, .tx_out_ready,
    .irq_pending, .rx_pkt_ready, .tx_pkt_ready);
  uepd_host uepd_host_inst (.sys_clk, .rst, .link(uepd_link_if_inst), .cfg_valid, .cfg_write,
    .cfg_addr, .cfg_wdata, .cfg_rdata, .cfg_rvalid, .xfer_dir_in, .wr_in_valid, .wr_in_data,
    .wr_in_ready, .rd_out_valid, .rd_out_data, .rd_out_ready, .irq_out);
  // Soft reset folded in so the shadows clear with the device
  uepd_properties_chk uepd_properties_chk_inst (.sys_clk, .rst(rst | soft_reset),
    .dma_request_out(uepd_link_if_inst.dma_request_out),
    .dma_acknowledge_in(uepd_link_if_inst.dma_acknowledge_in),
    .dma_port_sel(uepd_link_if_inst.dma_port_sel), .dma_rd(uepd_link_if_inst.dma_rd),
    .dma_wr(uepd_link_if_inst.dma_wr), .mcu_cs(uepd_link_if_inst.mcu_cs),
    .mcu_wr(uepd_link_if_inst.mcu_wr), .mcu_addr(uepd_link_if_inst.mcu_addr),
    .mcu_wdata(uepd_link_if_inst.mcu_wdata), .mcu_rdata(uepd_link_if_inst.mcu_rdata));

  // 125 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Hang guard and transmit byte capture
  always @(posedge sys_clk) begin
    cyc++;
    if (tx_out_valid === 1'b1 && tx_out_ready) tx_seen.push_back(tx_out_data);
    if (cyc == 6000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task tick;
    @(posedge sys_clk);
    #1;
  endtask : tick
  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wait_for(ref logic f, input logic v);
    for (int k = 0; k < 200 && f !== v; k++) tick();
  endtask : wait_for
  task reg_write(input logic [7:0] a, input logic [7:0] d);
    cfg_valid = 1'b1; cfg_write = 1'b1; cfg_addr = a; cfg_wdata = d;
    tick();
    cfg_valid = 1'b0;
    tick();
  endtask : reg_write
  task reg_read(input logic [7:0] a, input logic [7:0] e);
    cfg_valid = 1'b1; cfg_write = 1'b0; cfg_addr = a;
    tick();
    cfg_valid = 1'b0;
    check("rvalid", cfg_rvalid, 16'h0001);
    check("rdata", cfg_rdata, e);
    tick();
  endtask : reg_read
  // Receiver stalls a cycle before taking each word
  task get(input logic [15:0] e);
    tick();
    wait_for(rd_out_valid, 1'b1);
    check("rx_word", rd_out_data, e);
    rd_out_ready = 1'b1;
    tick();
    rd_out_ready = 1'b0;
  endtask : get
  task put(input logic [15:0] w);
    tick();
    wr_in_valid = 1'b1; wr_in_data = w;
    wait_for(wr_in_ready, 1'b1);
    tick();
    wr_in_valid = 1'b0;
  endtask : put
  task rx_pkt(input logic [7:0] q[$]);
    rx_pkt_count = 7'(q.size()); rx_pkt_good = 1'b1;
    tick();
    rx_pkt_good = 1'b0;
    foreach (q[i]) begin
      rx_in_valid = 1'b1; rx_in_data = q[i];
      wait_for(rx_in_ready, 1'b1);
      tick();
    end
    rx_in_valid = 1'b0;
  endtask : rx_pkt
  task give_verdict;
    $display("COUNTS compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  initial begin
    {rst, irq_pending, tx_out_ready} = 3'b111;
    {soft_reset, ep_dir_in, rx_pkt_good, rx_in_valid, tx_fifo_prepared, tx_sent_ack} = '0;
    {tx_set_ready, cfg_valid, cfg_write, xfer_dir_in, wr_in_valid, rd_out_ready} = '0;
    {rx_pkt_count, rx_in_data, cfg_addr, cfg_wdata, wr_in_data} = '0;
    repeat (3) @(posedge sys_clk);
    #1 rst = 1'b0;
    // Reset levels, reset values, unmapped place, polarity switch
    check("req_pin", uepd_link_if_inst.dma_request_out, 16'h1);
    check("irq_pin", uepd_link_if_inst.interrupt_request_pin, 16'h0);
    reg_read(ADDR_PIN_POLARITY_SELECT, RST_PIN_POLARITY_SELECT);
    reg_read(ADDR_DMA_CONTROL, RST_DMA_CONTROL);
    reg_read(ADDR_DMA_REQUEST_INTERVAL, RST_DMA_REQUEST_INTERVAL);
    reg_write(8'h10, 8'h5A);
    reg_read(8'h10, UNMAPPED_READ);
    reg_write(ADDR_PIN_POLARITY_SELECT, 8'h07);
    reg_read(ADDR_PIN_POLARITY_SELECT, 8'h07);
    check("irq_pin", uepd_link_if_inst.interrupt_request_pin, 16'h1);
    check("irq_out", irq_out, 16'h1);
    irq_pending = 1'b0;
    $display("TEST reset and registers done");
    // Receive, 8 bit, single address and transfer, count prefix, interval 1
    reg_write(ADDR_DMA_REQUEST_INTERVAL, 8'h01);
    check("irq_out", irq_out, 16'h0);
    reg_write(ADDR_DMA_CONTROL, 8'h05);
    fork
      rx_pkt('{8'hA1, 8'hB2, 8'hC3});
      begin
        get(16'h0003);
        get(16'h00A1);
        get(16'h00B2);
        get(16'h00C3);
      end
    join
    wait_for(rx_pkt_ready, 1'b0);
    check("rx_ready", rx_pkt_ready, 16'h0);
    $display("TEST receive 8 bit done");
    // Receive, 16 bit, dual address, paused then resumed
    reg_write(ADDR_DMA_CONTROL, 8'h8F);
    fork
      rx_pkt('{8'hA1, 8'hB2, 8'hC3});
      begin
        repeat (12) tick();
        check("req_pin", uepd_link_if_inst.dma_request_out, 16'h0);
        check("rx_valid", rd_out_valid, 16'h0);
        reg_write(ADDR_DMA_CONTROL, 8'h0F);
        get(16'h0003);
        get(16'hB2A1);
        get(16'h00C3);
      end
    join
    $display("TEST receive 16 bit done");
    // Transmit, 16 bit demand, automatic ready at maximum size
    {ep_dir_in, xfer_dir_in, tx_fifo_prepared} = 3'b111;
    reg_write(ADDR_DMA_CONTROL, 8'h19);
    put(16'h2211);
    put(16'h4433);
    wait_for(tx_pkt_ready, 1'b1);
    check("tx_ready", tx_pkt_ready, 16'h1);
    check("req_pin", uepd_link_if_inst.dma_request_out, 16'h0);
    for (int k = 0; k < 50 && tx_seen.size() < 4; k++) tick();
    check("tx_bytes", 16'(tx_seen.size()), 16'h4);
    foreach (tx_seen[i]) check("tx_byte", tx_seen[i], 16'(8'h11 * (i + 1)));
    tx_sent_ack = 1'b1;
    tick();
    tx_sent_ack = 1'b0;
    tick();
    check("tx_ready", tx_pkt_ready, 16'h0);
    check("req_pin", uepd_link_if_inst.dma_request_out, 16'h1);
    tx_set_ready = 1'b1;
    tick();
    tx_set_ready = 1'b0;
    tick();
    check("tx_ready", tx_pkt_ready, 16'h1);
    $display("TEST transmit done");
    // Soft reset returns pins to reset polarity; held two cycles
    ep_dir_in = 1'b0;
    soft_reset = 1'b1;
    repeat (2) tick();
    soft_reset = 1'b0;
    tick();
    check("req_pin", uepd_link_if_inst.dma_request_out, 16'h1);
    check("irq_pin", uepd_link_if_inst.interrupt_request_pin, 16'h1);
    reg_read(ADDR_DMA_CONTROL, RST_DMA_CONTROL);
    $display("TEST soft reset done");
    give_verdict();
  end
endmodule : usb_bulk_ep_dma_request_interface_bench
